// *** common/reset_idle_pkg.sv ***
package reset_idle_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLOCK_HZ = 10_000_000;
    localparam int OSC_PER_MACHINE_CYCLE = 6;
    localparam int PIN_MIN_MACHINE_CYCLES = 2;
    localparam int WDT_PULSE_MACHINE_CYCLES = 3;
    localparam int PIN_MIN_OSC = OSC_PER_MACHINE_CYCLE * PIN_MIN_MACHINE_CYCLES;
    localparam int WDT_PULSE_OSC = OSC_PER_MACHINE_CYCLE * WDT_PULSE_MACHINE_CYCLES;
    localparam int POR_STRETCH_MACHINE_CYCLES = 2;
    localparam int POR_STRETCH_OSC = OSC_PER_MACHINE_CYCLE * POR_STRETCH_MACHINE_CYCLES;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] PIN_MIN_CNT = CNT_W'(PIN_MIN_OSC);
    localparam logic [CNT_W-1:0] WDT_PULSE_CNT = CNT_W'(WDT_PULSE_OSC);
    localparam logic [CNT_W-1:0] POR_STRETCH_CNT = CNT_W'(POR_STRETCH_OSC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // ************************************************************
    // auxiliary_control_one layout
    // ************************************************************
    localparam int SOFTWARE_RESET_BIT = 5;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE
    } cpu_mode_e;

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic por_done;
        logic [CNT_W-1:0] pin_count;
        logic [CNT_W-1:0] wdt_count;
        logic [CNT_W-1:0] por_count;
        cpu_mode_e mode;
        logic reset_out;
        logic pin_pullup;
        logic cpu_clk_en;
        logic fetch_en;
    } state_s;

endpackage

// *** src/reset_and_idle_control.sv ***
// Behaviour
// R01: pin high for twelve oscillator periods resets the device
// R02: power-on detector resets the device without pin activity
// R03: watchdog overflow pulls the reset pin high for exactly three machine cycles
// R04: enabled watchdog overflow resets internally regardless of pin level
// R05: writing one to software reset bit, bit 5, resets the device
// R06: fully static; state holds while the clock is slowed or stopped
// R07: idle request instruction completes last; no fetch until idle ends
// R08: idle gates the cpu clock while peripherals keep running
// R09: cpu state, ram and registers stay unchanged during idle
// R10: an enabled interrupt ends idle and resumes via its vector
// R11: a hardware reset also ends idle, restarting like power-on
// R12: board holds pin high for oscillator start plus two machine cycles
// R13: all sources merge into one synchronous reset released on the clock
`timescale 1ns/10ps
`default_nettype none
module reset_and_idle_control
    import reset_idle_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_reset_pin,
    input wire logic i_power_on_detect,
    input wire logic i_watchdog_overflow,
    input wire logic i_watchdog_reset_enable,
    input wire logic i_aux_write,
    input wire logic [7:0] i_aux_wdata,
    input wire logic i_idle_request,
    input wire logic i_instr_done,
    input wire logic i_interrupt_pending,
    output logic o_reset,
    output logic o_reset_pin_out,
    output logic o_reset_pin_oe,
    output logic o_cpu_clk_en,
    output logic o_fetch_en
);

    // ************************************************************
    // state
    // ************************************************************
    state_s state;
    state_s next_state;
    logic pin_reset;
    logic wdt_reset;
    logic sw_reset;
    logic any_reset;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        next_state.pin_meta = i_reset_pin;
        next_state.pin_sync = state.pin_meta;
        // ************************************************************
        // pin qualification
        // ************************************************************
        if (state.pin_sync) begin
            if (state.pin_count != PIN_MIN_CNT) begin
                next_state.pin_count = state.pin_count + CNT_ONE;
            end
        end else begin
            next_state.pin_count = CNT_ZERO;
        end
        pin_reset = state.pin_sync && (state.pin_count == PIN_MIN_CNT - CNT_ONE); // R01
        // ************************************************************
        // watchdog pulse
        // ************************************************************
        wdt_reset = 1'b0;
        if (i_watchdog_overflow && state.wdt_count == CNT_ZERO) begin
            next_state.wdt_count = WDT_PULSE_CNT; // R03
            wdt_reset = i_watchdog_reset_enable; // R04
        end else if (state.wdt_count != CNT_ZERO) begin
            next_state.wdt_count = state.wdt_count - CNT_ONE;
        end
        next_state.pin_pullup = (next_state.wdt_count != CNT_ZERO); // R03
        sw_reset = i_aux_write && i_aux_wdata[SOFTWARE_RESET_BIT]; // R05
        // ************************************************************
        // power-on stretch
        // ************************************************************
        if (i_power_on_detect) begin
            next_state.por_count = POR_STRETCH_CNT; // R02
        end else if (state.por_count != CNT_ZERO) begin
            next_state.por_count = state.por_count - CNT_ONE;
        end
        // ************************************************************
        // reset merge
        // ************************************************************
        any_reset = pin_reset || wdt_reset || sw_reset || i_power_on_detect
            || (state.pin_sync && state.pin_count == PIN_MIN_CNT)
            || (state.por_count != CNT_ZERO); // R13
        next_state.reset_out = any_reset; // R13
        // ************************************************************
        // idle control
        // ************************************************************
        unique case (state.mode)
            MODE_RUN: begin
                next_state.cpu_clk_en = 1'b1;
                next_state.fetch_en = 1'b1;
                if (i_idle_request && i_instr_done) begin
                    next_state.mode = MODE_IDLE; // R07
                    next_state.cpu_clk_en = 1'b0; // R08
                    next_state.fetch_en = 1'b0; // R07
                end
            end
            MODE_IDLE: begin
                next_state.cpu_clk_en = 1'b0; // R09
                next_state.fetch_en = 1'b0;
                if (i_interrupt_pending) begin
                    next_state.mode = MODE_RUN; // R10
                    next_state.cpu_clk_en = 1'b1;
                    next_state.fetch_en = 1'b1;
                end
            end
            default: begin
                next_state.mode = MODE_RUN;
            end
        endcase
        if (any_reset) begin
            next_state.mode = MODE_RUN; // R11
            next_state.cpu_clk_en = 1'b1;
            next_state.fetch_en = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state <= '{
                pin_meta: 1'b0,
                pin_sync: 1'b0,
                por_done: 1'b0,
                pin_count: CNT_ZERO,
                wdt_count: CNT_ZERO,
                por_count: POR_STRETCH_CNT,
                mode: MODE_RUN,
                reset_out: 1'b1,
                pin_pullup: 1'b0,
                cpu_clk_en: 1'b1,
                fetch_en: 1'b1
            };
        end else begin
            state <= next_state; // R06
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_reset = state.reset_out;
    assign o_reset_pin_out = state.pin_pullup;
    assign o_reset_pin_oe = state.pin_pullup;
    assign o_cpu_clk_en = state.cpu_clk_en;
    assign o_fetch_en = state.fetch_en;

    // ************************************************************
    // check helpers
    // ************************************************************
    logic [CNT_W-1:0] oe_run;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            oe_run <= CNT_ZERO;
        end else if (!o_reset_pin_oe) begin
            oe_run <= CNT_ZERO;
        end else if (oe_run != WDT_PULSE_CNT + CNT_ONE) begin
            oe_run <= oe_run + CNT_ONE;
        end
    end

    // ************************************************************
    // checks: reset sources
    // ************************************************************
    AST_PIN_RESET: assert property (@(posedge i_clock) disable iff (!i_resetn) // R01
        (state.pin_sync && state.pin_count == PIN_MIN_CNT - CNT_ONE) |=> o_reset)
        else $error("qualified pin did not reset");

    AST_PIN_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn) // R01
        (state.pin_sync && state.pin_count == PIN_MIN_CNT) |=> o_reset)
        else $error("reset dropped while pin held high");

    AST_PIN_COUNT_CLEAR: assert property (@(posedge i_clock) disable iff (!i_resetn) // R01
        !state.pin_sync |=> state.pin_count == CNT_ZERO)
        else $error("pin count kept after pin went low");

    AST_PIN_SYNC_CHAIN: assert property (@(posedge i_clock) disable iff (!i_resetn) // R01
        state.pin_sync == $past(state.pin_meta))
        else $error("pin synchroniser chain broken");

    AST_POD_RESET: assert property (@(posedge i_clock) disable iff (!i_resetn) // R02
        i_power_on_detect |=> o_reset [*8])
        else $error("power-on detect did not hold reset");

    AST_POD_STRETCH: assert property (@(posedge i_clock) disable iff (!i_resetn) // R02
        (state.por_count != CNT_ZERO) |=> o_reset)
        else $error("reset dropped during power-on stretch");

    AST_POD_RELOAD: assert property (@(posedge i_clock) disable iff (!i_resetn) // R02
        i_power_on_detect |=> state.por_count == POR_STRETCH_CNT)
        else $error("power-on stretch not reloaded");

    AST_WDT_PULSE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R03
        $fell(o_reset_pin_oe) |-> oe_run == WDT_PULSE_CNT)
        else $error("watchdog pulse length wrong");

    AST_WDT_START: assert property (@(posedge i_clock) disable iff (!i_resetn) // R03
        (i_watchdog_overflow && state.wdt_count == CNT_ZERO)
        |=> o_reset_pin_oe && o_reset_pin_out)
        else $error("watchdog pulse did not start");

    AST_WDT_REFUSED: assert property (@(posedge i_clock) disable iff (!i_resetn) // R03
        (state.wdt_count > CNT_ONE) |=> state.wdt_count == $past(state.wdt_count) - CNT_ONE)
        else $error("running watchdog pulse restarted");

    AST_WDT_LEVEL: assert property (@(posedge i_clock) disable iff (!i_resetn) // R03
        o_reset_pin_oe |-> o_reset_pin_out)
        else $error("pull-up enabled without high level");

    AST_WDT_ONLY_SOURCE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R03
        $rose(o_reset_pin_oe) |-> $past(i_watchdog_overflow))
        else $error("pull-up started without overflow");

    AST_WDT_INTERNAL: assert property (@(posedge i_clock) disable iff (!i_resetn) // R04
        (i_watchdog_overflow && i_watchdog_reset_enable && !o_reset_pin_oe) |=> o_reset)
        else $error("enabled overflow did not reset");

    AST_WDT_PIN_LOW: assert property (@(posedge i_clock) disable iff (!i_resetn) // R04
        (i_watchdog_overflow && i_watchdog_reset_enable && state.wdt_count == CNT_ZERO
        && !state.pin_sync) |=> o_reset)
        else $error("overflow reset depended on pin");

    AST_SW_RESET: assert property (@(posedge i_clock) disable iff (!i_resetn) // R05
        (i_aux_write && i_aux_wdata[SOFTWARE_RESET_BIT]) |=> o_reset)
        else $error("software reset ignored");

    AST_SW_OTHER_BITS: assert property (@(posedge i_clock) disable iff (!i_resetn) // R05
        (i_aux_write && !i_aux_wdata[SOFTWARE_RESET_BIT] && !any_reset) |=> !o_reset)
        else $error("write without reset bit caused reset");

    AST_RESET_MERGE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R13
        any_reset |=> o_reset)
        else $error("merged reset not registered");

    AST_RESET_RELEASE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R13
        !any_reset |=> !o_reset)
        else $error("reset held without source");

    AST_RESET_ROSE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R13
        $rose(o_reset) |-> $past(any_reset))
        else $error("reset rose without source");

    // ************************************************************
    // checks: idle
    // ************************************************************
    AST_IDLE_ENTRY: assert property (@(posedge i_clock) disable iff (!i_resetn) // R07
        (state.mode == MODE_RUN && i_idle_request && i_instr_done && !any_reset)
        |=> !o_fetch_en && !o_cpu_clk_en)
        else $error("idle entry failed");

    AST_IDLE_FETCH_OFF: assert property (@(posedge i_clock) disable iff (!i_resetn) // R07
        state.mode == MODE_IDLE |-> !o_fetch_en)
        else $error("fetch allowed in idle");

    AST_RUN_STAYS: assert property (@(posedge i_clock) disable iff (!i_resetn) // R07
        (state.mode == MODE_RUN && !(i_idle_request && i_instr_done))
        |=> state.mode == MODE_RUN && o_cpu_clk_en)
        else $error("idle entered without request");

    AST_IDLE_GATES: assert property (@(posedge i_clock) disable iff (!i_resetn) // R08
        state.mode == MODE_IDLE |-> !o_cpu_clk_en)
        else $error("cpu clock enabled in idle");

    AST_FETCH_WITH_CLOCK: assert property (@(posedge i_clock) disable iff (!i_resetn) // R08
        o_fetch_en == o_cpu_clk_en)
        else $error("fetch and cpu clock disagree");

    AST_IDLE_HOLD: assert property (@(posedge i_clock) disable iff (!i_resetn) // R09
        (state.mode == MODE_IDLE && !i_interrupt_pending && !any_reset) |=> !o_cpu_clk_en)
        else $error("cpu clock ran in idle");

    AST_IDLE_STAYS: assert property (@(posedge i_clock) disable iff (!i_resetn) // R09
        (state.mode == MODE_IDLE && !i_interrupt_pending && !any_reset)
        |=> state.mode == MODE_IDLE)
        else $error("idle left without cause");

    AST_IDLE_WAKE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R10
        (state.mode == MODE_IDLE && i_interrupt_pending) |=> o_cpu_clk_en && o_fetch_en)
        else $error("interrupt did not end idle");

    AST_RESET_WAKE: assert property (@(posedge i_clock) disable iff (!i_resetn) // R11
        (state.mode == MODE_IDLE && any_reset) |=> o_cpu_clk_en && state.mode == MODE_RUN)
        else $error("reset did not end idle");

    AST_RESET_RUNS_CPU: assert property (@(posedge i_clock) disable iff (!i_resetn) // R11
        o_reset |-> o_cpu_clk_en && o_fetch_en)
        else $error("cpu clock gated during reset");

endmodule
`default_nettype wire

// *** test/board_reset_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************
// board reset circuit
// ****************
module board_reset_model (
    input wire logic i_press,
    input wire logic i_pullup_out,
    input wire logic i_pullup_oe,
    output logic o_pin
);
    // board pull-down keeps pin low when nobody drives it
    assign o_pin = i_press | (i_pullup_oe & i_pullup_out);
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench
    import reset_idle_pkg::*;
;
    logic i_clock, i_resetn, run, press, power_on_detector, wdo, wde, aw, req, done, irq, pin;
    logic rst, pin_out, pin_oe, clk_en, fetch;
    logic [7:0] wd;
    int errors, n_compared, k;
    // ****************
    // clock, partner, design
    // ****************
    initial begin
        i_clock = 1'b0;
        forever #50 if (run) i_clock = ~i_clock;
    end
    board_reset_model board (.i_press(press), .i_pullup_out(pin_out), .i_pullup_oe(pin_oe),
        .o_pin(pin));
    reset_and_idle_control DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_reset_pin(pin),
        .i_power_on_detect(power_on_detector), .i_watchdog_overflow(wdo), .i_watchdog_reset_enable(wde),
        .i_aux_write(aw), .i_aux_wdata(wd), .i_idle_request(req), .i_instr_done(done),
        .i_interrupt_pending(irq), .o_reset(rst), .o_reset_pin_out(pin_out),
        .o_reset_pin_oe(pin_oe), .o_cpu_clk_en(clk_en), .o_fetch_en(fetch));
    task automatic compare(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_pin;
        cyc(1); press <= 1'b1;
        cyc(10); press <= 1'b0;
        k = 0;
        repeat (20) begin cyc(1); #1 if (rst !== 1'b0) k++; end
        compare(k == 0, 1'b1);
        cyc(1); press <= 1'b1;
        cyc(20); #1 compare(rst, 1'b1);
        cyc(1); press <= 1'b0;
        cyc(20); #1 compare(rst, 1'b0);
        $display("test pin done");
    endtask
    task automatic t_pod;
        cyc(1); power_on_detector <= 1'b1;
        cyc(1); power_on_detector <= 1'b0;
        #1 compare(rst, 1'b1);
        cyc(8); #1 compare(rst, 1'b1);
        cyc(8); #1 compare(rst, 1'b0);
        $display("test detector done");
    endtask
    task automatic t_wdt;
        cyc(1); wdo <= 1'b1;
        cyc(1); wdo <= 1'b0;
        #1 compare(rst, 1'b1);
        k = 0;
        repeat (30) begin if (pin_oe === 1'b1 && pin_out === 1'b1) k++; cyc(1); #1; end
        compare(k == WDT_PULSE_OSC, 1'b1);
        cyc(20); #1 compare(rst, 1'b0);
        $display("test watchdog done");
    endtask
    task automatic t_soft;
        cyc(1); aw <= 1'b1; wd <= 8'hdf;
        cyc(1); aw <= 1'b0;
        #1 compare(rst, 1'b0);
        cyc(1); aw <= 1'b1; wd <= 8'h20;
        cyc(1); aw <= 1'b0;
        #1 compare(rst, 1'b1);
        cyc(20);
        $display("test software done");
    endtask
    task automatic t_idle;
        cyc(1); req <= 1'b1; done <= 1'b1;
        cyc(1); req <= 1'b0; done <= 1'b0;
        #1 compare(clk_en, 1'b0);
        compare(fetch, 1'b0);
        run = 1'b0;
        #1000 run = 1'b1;
        cyc(3); #1 compare(fetch, 1'b0);
        compare(rst, 1'b0);
        cyc(1); irq <= 1'b1;
        cyc(1); irq <= 1'b0;
        #1 compare(clk_en, 1'b1);
        compare(fetch, 1'b1);
        cyc(1); req <= 1'b1; done <= 1'b1;
        cyc(1); req <= 1'b0; done <= 1'b0;
        cyc(2); power_on_detector <= 1'b1;
        cyc(1); power_on_detector <= 1'b0;
        #1 compare(clk_en, 1'b1);
        compare(rst, 1'b1);
        cyc(20);
        $display("test idle done");
    endtask
    initial begin
        {run, i_resetn, press, power_on_detector, wdo, wde, aw, req, done, irq} = 10'h210;
        wd = 8'h00;
        errors = 0;
        n_compared = 0;
        cyc(4); i_resetn <= 1'b1;
        cyc(4); #1 compare(rst, 1'b1);
        cyc(16); #1 compare(rst, 1'b0);
        t_pin;
        t_pod;
        t_wdt;
        t_soft;
        t_idle;
        report_and_stop;
    end
    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
